// ===== src/phy_rx_status.sv
// receive error, collision and carrier sense outputs of the phy
`default_nettype none
module phy_rx_status (
  // clock and reset
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_n,
  // configuration
  input  wire rx_status_pkg::if_mode_e i_if_mode,
  input  wire logic                    i_full_duplex,
  input  wire logic                    i_repeater_strap,
  // medium status from the line side
  input  wire logic                    i_rx_active,
  input  wire logic                    i_tx_active,
  input  wire logic                    i_medium_collision,
  input  wire logic                    i_rx_error_detect,
  input  wire logic                    i_rx_data_valid,
  // mac side outputs
  output logic                         o_rx_data_valid,
  output logic                         o_crs_dv,
  output logic                         o_rx_error,
  output logic                         o_collision,
  output logic                         o_carrier_sense,
  output logic                         o_repeater_mode
);
  //============================================================================
  // strap
  rx_status_if strap ();

  strap_capture u_strap (
    .i_sys_clk        (i_sys_clk),
    .i_rst_n          (i_rst_n),
    .i_repeater_strap (i_repeater_strap),
    .strap            (strap.source)
  );

  //============================================================================
  // decode helpers, shared by the registered and the pass-through paths
  function automatic logic mode_is_mii(input rx_status_pkg::if_mode_e mode);
    logic hit;
    hit = 1'b0;
    case (mode)
      rx_status_pkg::MODE_MII: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : mode_is_mii

  function automatic logic mode_is_rmii(input rx_status_pkg::if_mode_e mode);
    logic hit;
    hit = 1'b0;
    case (mode)
      rx_status_pkg::MODE_RMII: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : mode_is_rmii

  // the line that keeps a reported error standing differs by mode
  function automatic logic err_frame_open(
    input rx_status_pkg::if_mode_e mode,
    input logic                    data_valid,
    input logic                    rx_active
  );
    logic held;
    held = 1'b0;
    case (mode)
      rx_status_pkg::MODE_MII: begin
        held = data_valid;
      end
      rx_status_pkg::MODE_RMII: begin
        held = rx_active;
      end
      rx_status_pkg::MODE_SEVEN_WIRE_SERIAL: begin
        held = 1'b0;
      end
      default: begin
        held = 1'b0;
      end
    endcase
    return held;
  endfunction : err_frame_open

  // collision is a pin of the mii and serial modes, never driven at full duplex
  function automatic logic collision_out(
    input rx_status_pkg::if_mode_e mode,
    input logic                    full_duplex,
    input logic                    collision
  );
    logic col;
    col = 1'b0;
    if (full_duplex) begin
      col = 1'b0;
    end else if (!mode_is_rmii(mode)) begin
      col = collision;
    end
    return col;
  endfunction : collision_out

  // a repeater drops the transmit term so its own sending does not defer it
  function automatic logic half_duplex_sense(
    input logic repeater,
    input logic rx_active,
    input logic tx_active
  );
    logic sense;
    sense = rx_active | tx_active;
    if (repeater) begin
      sense = rx_active;
    end
    return sense;
  endfunction : half_duplex_sense

  // carrier sense is a pin of the mii and serial modes only
  function automatic logic carrier_out(
    input rx_status_pkg::if_mode_e mode,
    input logic                    full_duplex,
    input logic                    half_term,
    input logic                    rx_active
  );
    logic crs;
    crs = 1'b0;
    if (!mode_is_rmii(mode)) begin
      crs = full_duplex ? rx_active : half_term;
    end
    return crs;
  endfunction : carrier_out

  //============================================================================
  // mode decode
  logic is_mii;
  logic is_rmii;
  logic frame_held;

  assign is_mii     = mode_is_mii(i_if_mode);
  assign is_rmii    = mode_is_rmii(i_if_mode);
  assign frame_held = err_frame_open(i_if_mode, i_rx_data_valid, i_rx_active);

  //============================================================================
  // receive error, registered on the receive clock
  logic rx_error;
  logic next_rx_error;

  always_comb begin
    next_rx_error = 1'b0;
    case (i_if_mode)
      rx_status_pkg::MODE_MII: begin
        // sticky until data valid falls; a new error still sets
        next_rx_error = i_rx_error_detect | (rx_error & frame_held);
      end
      rx_status_pkg::MODE_RMII: begin
        next_rx_error = i_rx_error_detect | (rx_error & frame_held);
      end
      rx_status_pkg::MODE_SEVEN_WIRE_SERIAL: begin
        next_rx_error = 1'b0;
      end
      default: begin
        next_rx_error = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (i_rst_n == rx_status_pkg::RST_LOW) begin
      rx_error <= 1'b0;
    end else begin
      rx_error <= next_rx_error;
    end
  end

  assign o_rx_error = rx_error;

  //============================================================================
  // receive data valid, one receive clock behind the line side in mii mode, held low in the other modes
  logic rx_dv;
  logic next_rx_dv;

  always_comb begin
    next_rx_dv = 1'b0;
    if (is_mii) begin
      next_rx_dv = i_rx_data_valid;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (i_rst_n == rx_status_pkg::RST_LOW) begin
      rx_dv <= 1'b0;
    end else begin
      rx_dv <= next_rx_dv;
    end
  end

  assign o_rx_data_valid = rx_dv;

  //============================================================================
  // unsynchronised status: crs/dv, collision and carrier sense pass straight through, no clock delay by design; the repeater strap is registered
  logic repeater_active;
  logic half_sense;

  // before the capture edge the block behaves as a switch or adapter
  assign repeater_active = strap.strap_valid & (strap.repeater_mode == rx_status_pkg::STRAP_REPEATER);

  // crs/dv asserts on a non-idle receive medium, in rmii mode only
  assign o_crs_dv = is_rmii & i_rst_n & i_rx_active;

  // no collision output in rmii; full duplex forces it low
  assign o_collision = i_rst_n & collision_out(i_if_mode, i_full_duplex, i_medium_collision);

  assign half_sense      = half_duplex_sense(repeater_active, i_rx_active, i_tx_active);
  assign o_carrier_sense = i_rst_n & carrier_out(i_if_mode, i_full_duplex, half_sense, i_rx_active);

  // captured strap, stable until the next reset
  assign o_repeater_mode = strap.repeater_mode;
endmodule : phy_rx_status
`default_nettype wire

// ===== src/rx_status_pkg.sv
// constants and types for the phy receive status and strap block
//==============================================================================
`default_nettype none
package rx_status_pkg;
  //============================================================================
  // interface modes
  typedef enum logic [2:0] {
    MODE_MII                  = 3'b001,
    MODE_RMII                 = 3'b010,
    MODE_SEVEN_WIRE_SERIAL    = 3'b100
  } if_mode_e;
  //============================================================================
  // strap meaning and reset values
  localparam logic STRAP_SWITCH_OR_ADAPTER = 1'b0;
  localparam logic STRAP_REPEATER          = 1'b1;
  localparam logic RST_LOW                 = 1'b0;
  // recommended reset hold, far side obligation only
  localparam int   RESET_HOLD_MS           = 200;
endpackage : rx_status_pkg
`default_nettype wire

// ===== src/rx_status_if.sv
// interface carrying the strap capture result to the status logic
`default_nettype none
interface rx_status_if;
  logic repeater_mode;
  logic strap_valid;
  modport source (output repeater_mode, output strap_valid);
  modport sink   (input  repeater_mode, input  strap_valid);
endinterface : rx_status_if
`default_nettype wire

// ===== src/strap_capture.sv
// repeater strap capture at reset release
`default_nettype none
module strap_capture (
  // clock and reset
  input  wire logic   i_sys_clk,
  input  wire logic   i_rst_n,
  // strap pin
  input  wire logic   i_repeater_strap,
  // result
  rx_status_if.source strap
);
  //============================================================================
  // capture state
  logic captured;
  logic next_captured;
  logic mode;
  logic next_mode;

  // async reset may only load a constant, so the pin is sampled on the first edge after release
  always_comb begin
    next_captured = 1'b1;
    next_mode     = captured ? mode : i_repeater_strap;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (i_rst_n == rx_status_pkg::RST_LOW) begin
      captured <= 1'b0;
      mode     <= rx_status_pkg::STRAP_SWITCH_OR_ADAPTER;
    end else begin
      captured <= next_captured;
      mode     <= next_mode;
    end
  end

  assign strap.repeater_mode = mode;
  assign strap.strap_valid   = captured;
endmodule : strap_capture
`default_nettype wire

// ===== sim/phy_rx_status_chk.sv
// assertions on the phy receive status ports
`default_nettype none
module phy_rx_status_chk (
  input wire logic i_sys_clk, i_rst_n, i_full_duplex, i_repeater_strap, i_rx_active, i_tx_active,
  input wire logic i_medium_collision, i_rx_error_detect, i_rx_data_valid, o_rx_data_valid, o_crs_dv,
  input wire logic o_rx_error, o_collision, o_carrier_sense, o_repeater_mode,
  input wire rx_status_pkg::if_mode_e i_if_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  //============================================================================
  // properties
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire mii  = i_if_mode == rx_status_pkg::MODE_MII;
  wire rmii = i_if_mode == rx_status_pkg::MODE_RMII;
  a_err_set_detect: assert property ((mii || rmii) && i_rx_error_detect |=> o_rx_error)
    else $error("no err");
  a_err_hold_mii: assert property (mii && o_rx_error && i_rx_data_valid |=> o_rx_error)
    else $error("err lost");
  a_err_hold_rmii: assert property (rmii && o_rx_error && i_rx_active |=> o_rx_error)
    else $error("err lost rmii");
  a_err_clr_mii: assert property (mii && !i_rx_data_valid && !i_rx_error_detect |=> !o_rx_error)
    else $error("err stuck");
  a_err_clr_rmii: assert property (rmii && !i_rx_active && !i_rx_error_detect |=> !o_rx_error)
    else $error("err stuck rmii");
  a_err_serial_quiet: assert property (!(mii || rmii) |=> !o_rx_error)
    else $error("err serial");
  a_col_half: assert property (!rmii && !i_full_duplex |-> o_collision == i_medium_collision)
    else $error("col");
  a_col_full_low: assert property (i_full_duplex |-> !o_collision)
    else $error("col full");
  a_crs_by_mode: assert property (!rmii && !i_full_duplex |->
    o_carrier_sense == (i_rx_active || (i_tx_active && !o_repeater_mode))) else $error("crs");
  a_crsdv_follow: assert property (rmii |-> o_crs_dv == i_rx_active)
    else $error("crs_dv");
  a_dv_delay: assert property (mii |=> o_rx_data_valid == $past(i_rx_data_valid))
    else $error("dv");
  a_strap_catch: assert property ($rose(i_rst_n) |=> o_repeater_mode == $past(i_repeater_strap))
    else $error("strap");
  a_strap_steady: assert property ($past(i_rst_n, 2) |-> $stable(o_repeater_mode))
    else $error("strap moved");
  a_reset_quiet: assert property (disable iff (1'h0) !i_rst_n |-> !o_rx_error && !o_repeater_mode && !o_crs_dv)
    else $error("reset");
  c_err: cover property (o_rx_error);
  c_col: cover property (o_collision);
  c_crs_dv: cover property (o_crs_dv);
endmodule : phy_rx_status_chk
bind phy_rx_status phy_rx_status_chk phy_rx_status_chk_i (.*);
`default_nettype wire

// ===== sim/mac_model.sv
// mac side model sampling the receive error on the clock
`default_nettype none
module mac_model (
  input  wire logic i_sys_clk,
  input  wire logic i_rx_error,
  output var logic  o_err_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  // sampled on the edge, so an unsynchronised error would show late
  always_ff @(posedge i_sys_clk) o_err_seen <= i_rx_error;
endmodule : mac_model
`default_nettype wire

// ===== sim/phy_rx_status_tb_top.sv
// testbench for the phy receive status block
`default_nettype none
module phy_rx_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 0, i_rst_n = 0, i_full_duplex = 0, i_repeater_strap = 0, i_rx_active = 0;
  logic i_tx_active = 0, i_medium_collision = 0, i_rx_error_detect = 0, i_rx_data_valid = 0;
  rx_status_pkg::if_mode_e i_if_mode = rx_status_pkg::MODE_MII;
  logic o_rx_data_valid, o_crs_dv, o_rx_error, o_collision, o_carrier_sense, o_repeater_mode, err_seen;
  int mismatches = 0, check_count = 0;
  phy_rx_status phy_rx_status_i (
    .i_sys_clk          (i_sys_clk),
    .i_rst_n            (i_rst_n),
    .i_if_mode          (i_if_mode),
    .i_full_duplex      (i_full_duplex),
    .i_repeater_strap   (i_repeater_strap),
    .i_rx_active        (i_rx_active),
    .i_tx_active        (i_tx_active),
    .i_medium_collision (i_medium_collision),
    .i_rx_error_detect  (i_rx_error_detect),
    .i_rx_data_valid    (i_rx_data_valid),
    .o_rx_data_valid    (o_rx_data_valid),
    .o_crs_dv           (o_crs_dv),
    .o_rx_error         (o_rx_error),
    .o_collision        (o_collision),
    .o_carrier_sense    (o_carrier_sense),
    .o_repeater_mode    (o_repeater_mode)
  );
  mac_model mac_model_i (.i_sys_clk(i_sys_clk), .i_rx_error(o_rx_error), .o_err_seen(err_seen));
  initial forever #20 i_sys_clk = ~i_sys_clk;
  //============================================================================
  // helpers
  task automatic tick(int n = 1); repeat (n) @(negedge i_sys_clk); endtask : tick
  task automatic chk(string n, logic s, logic e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", n, e, s);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // short hold keeps the run brief
  task automatic rst(logic strap);
    i_rst_n = 1'h0;
    i_repeater_strap = strap;
    tick(4);
    chk("reset quiet", o_rx_error | o_repeater_mode, 1'h0);
    i_rst_n = 1'h1;
    tick(2);
  endtask : rst
  //============================================================================
  // scenarios
  task automatic t_err();
    rx_status_pkg::if_mode_e m[3] = '{rx_status_pkg::MODE_MII, rx_status_pkg::MODE_RMII,
                                      rx_status_pkg::MODE_SEVEN_WIRE_SERIAL};
    for (int k = 0; k < 3; k++) begin
      i_if_mode = m[k];
      {i_rx_data_valid, i_rx_active, i_rx_error_detect} = 3'h7;
      tick();
      i_rx_error_detect = 1'h0;
      tick(3);
      chk("rx_error hold", o_rx_error, k < 2);
      chk("mac sees error", err_seen, k < 2);
      chk("rx_dv", o_rx_data_valid, k == 0);
      if (k == 0) i_rx_data_valid = 1'h0;
      else i_rx_active = 1'h0;
      tick();
      chk("rx_error clear", o_rx_error, 1'h0);
      {i_rx_data_valid, i_rx_active} = 2'h0;
    end
    $display("done t_err");
  endtask : t_err
  task automatic t_col();
    i_medium_collision = 1'h1;
    tick();
    chk("col half", o_collision, 1'h1);
    i_full_duplex = 1'h1;
    tick();
    chk("col full", o_collision, 1'h0);
    i_full_duplex = 1'h0;
    i_if_mode = rx_status_pkg::MODE_SEVEN_WIRE_SERIAL;
    tick();
    chk("col serial", o_collision, 1'h1);
    i_if_mode = rx_status_pkg::MODE_RMII;
    tick();
    chk("col rmii", o_collision, 1'h0);
    i_if_mode = rx_status_pkg::MODE_MII;
    {i_full_duplex, i_medium_collision} = 2'h0;
    $display("done t_col");
  endtask : t_col
  task automatic t_crs(logic strap);
    rst(strap);
    chk("repeater mode", o_repeater_mode, strap);
    i_tx_active = 1'h1;
    tick();
    chk("crs on tx", o_carrier_sense, !strap);
    {i_tx_active, i_rx_active} = 2'h1;
    tick();
    chk("crs on rx", o_carrier_sense, 1'h1);
    i_if_mode = rx_status_pkg::MODE_RMII;
    tick();
    chk("crs_dv", o_crs_dv, 1'h1);
    chk("crs in rmii", o_carrier_sense, 1'h0);
    i_rx_active = 1'h0;
    i_if_mode = rx_status_pkg::MODE_MII;
    $display("done t_crs");
  endtask : t_crs
  initial begin
    rst(1'h0);
    t_err();
    t_col();
    t_crs(1'h0);
    t_crs(1'h1);
    summarize();
  end
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule : phy_rx_status_tb_top
`default_nettype wire
